// file: src/dsc_pkg.sv
package dsc_pkg;

  // Register indices on the serial register port.
  localparam logic [4:0] DSC_ADDR_OFFSET_A_HIGH   = 5'h12;
  localparam logic [4:0] DSC_ADDR_OFFSET_B_HIGH   = 5'h13;
  localparam logic [4:0] DSC_ADDR_HOST_SAMPLE_LOW = 5'h14;
  localparam logic [4:0] DSC_ADDR_HOST_SAMPLE_HI  = 5'h15;
  localparam logic [4:0] DSC_ADDR_DATAPATH_TRIG   = 5'h16;
  localparam logic [4:0] DSC_ADDR_FIFO_TRIG       = 5'h17;
  localparam logic [4:0] DSC_ADDR_FIFO_START      = 5'h18;
  localparam logic [4:0] DSC_ADDR_SPARE_A         = 5'h19;
  localparam logic [4:0] DSC_ADDR_POWER_PAD       = 5'h1a;
  localparam logic [4:0] DSC_ADDR_COARSE_SCALE    = 5'h1b;
  localparam logic [4:0] DSC_ADDR_SPARE_B         = 5'h1c;
  localparam logic [4:0] DSC_ADDR_SPARE_C         = 5'h1d;

  // Values after reset.
  localparam logic [7:0] DSC_RST_OFFSET_HIGH   = 8'h00;
  localparam logic [7:0] DSC_RST_HOST_SAMPLE   = 8'h00;
  localparam logic [7:0] DSC_RST_DATAPATH_TRIG = 8'h15;
  localparam logic [7:0] DSC_RST_FIFO_TRIG     = 8'h15;
  localparam logic [7:0] DSC_RST_FIFO_START    = 8'h80;
  localparam logic [7:0] DSC_RST_POWER_PAD     = 8'h0e;
  localparam logic [7:0] DSC_RST_COARSE_SCALE  = 8'hff;

  // Field positions (lowest bit of each field).
  localparam int DSC_POS_OSC_ACCUM   = 6;
  localparam int DSC_POS_OSC_LOAD    = 4;
  localparam int DSC_POS_CORR_LOAD   = 2;
  localparam int DSC_POS_OFFSET_LOAD = 0;
  localparam int DSC_POS_FIFO_SEL    = 3;
  localparam int DSC_POS_AFLAG       = 2;
  localparam int DSC_POS_FIFO_START  = 4;
  localparam int DSC_POS_THRESHOLD   = 7;
  localparam int DSC_POS_SLEEP_B     = 5;
  localparam int DSC_POS_SLEEP_A     = 4;
  localparam int DSC_POS_BIAS_A      = 3;
  localparam int DSC_POS_BIAS_B      = 2;
  localparam int DSC_POS_COARSE_A    = 4;
  localparam int DSC_POS_COARSE_B    = 0;

  // FIFO sync source codes.
  localparam logic [2:0] DSC_FIFO_TX_PIN    = 3'h0;
  localparam logic [2:0] DSC_FIFO_SYNC_PIN  = 3'h1;
  localparam logic [2:0] DSC_FIFO_SERIAL    = 3'h2;
  localparam logic [2:0] DSC_FIFO_FIRST_A   = 3'h4;
  localparam logic [2:0] DSC_FIFO_FIRST_B   = 3'h5;
  localparam logic [2:0] DSC_FIFO_ALWAYS_ON = 3'h7;

  // Datapath sync choice shared by the four selector fields.
  typedef enum logic [1:0] {
    DSC_TRIG_TX_GATE,
    DSC_TRIG_FRAME_SYNC,
    DSC_TRIG_SERIAL,
    DSC_TRIG_NEVER
  } dsc_trig_t;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [4:0] addr;
    logic [7:0] wdata;
  } dsc_reg_req_t;

  typedef struct packed {
    logic tx_gate;
    logic frame_sync;
    logic serial_trigger;
  } dsc_sync_in_t;

endpackage

// file: src/dsc_msb_once.sv
`timescale 1ns/1ps
// Fires once on the first change of an input MSB, then stays quiet until re-armed.
module dsc_msb_once
  import dsc_pkg::*;
(
  // Clock and reset.
  input  wire logic clock,
  input  wire logic reset_n,
  // Control and data.
  input  wire logic rearm,
  input  wire logic msb,
  // Result.
  output logic      fire
);

  logic last;
  logic primed;
  logic armed;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      last   <= 1'b0;
      primed <= 1'b0;
    end else begin
      last   <= msb;
      primed <= 1'b1;
    end
  end

  // A re-arm in the same cycle as a transition wins, so the next change fires again.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      armed <= 1'b1;
      fire  <= 1'b0;
    end else begin
      fire  <= armed && primed && (msb != last) && !rearm;
      if (rearm) begin
        armed <= 1'b1;
      end else if (primed && (msb != last)) begin
        armed <= 1'b0;
      end
    end
  end

endmodule

// file: src/dsc_config_regs.sv
`timescale 1ns/1ps
// Summary of operation
// R1: Register 0x12 low five bits are channel A offset bits 12:8.
// R2: Register 0x13 low five bits are channel B offset bits 12:8.
// R3: Each channel's offset is added to its sample stream in converter LSBs.
// R4: Host sample is 0x15 bits as 15:8 over 0x14 bits as 7:0.
// R5: With host-sample enable, the host sample feeds both channels as two's complement.
// R6: 0x16 bits 7:6 pick the oscillator accumulator sync event.
// R7: 0x16 bits 5:4 pick the oscillator register transfer event.
// R8: 0x16 bits 3:2 pick the gain and phase correction load event.
// R9: 0x16 bits 1:0 pick the offset correction load event.
// R10: 0x17 bits 5:3 pick the FIFO sync source among six codes; codes 3 and 6 never sync.
// R11: First-MSB-transition FIFO sync fires once until reset or a write of a different code to the field.
// R12: 0x17 bit 2 picks opposite-port MSB or transmit-gate rising edge as A mark.
// R13: Each FIFO sync loads 0x18 bits 7:4 into the FIFO output position counter.
// R14: 0x1A bit 5 puts channel B to sleep.
// R15: 0x1A bit 4 sleeps channel A and forces channel B asleep too.
// R16: Clearing 0x1A bits 3 and 2 enables the bias filters; both reset high.
// R17: Software writes one to 0x1A bit 1 and zero to bit 0.
// R18: 0x1B nibbles scale full-scale current in 16 steps; both reset to ones.
// R19: 0x1A bit 7 selects 3.3 V pads at zero and 1.8 V pads at one.
// R20: Offsets reach the datapath only on their sync; 0x19, 0x1C, 0x1D read zero.
module dsc_config_regs
  import dsc_pkg::*;
(
  // Clock and reset.
  input  wire logic         clock,
  input  wire logic         reset_n,
  // Register port from the serial interface.
  input  wire dsc_reg_req_t reg_req,
  output logic [7:0]        reg_rdata,
  output logic              reg_rvalid,
  // Sync sources after the FIFO and from the serial port.
  input  wire dsc_sync_in_t sync_in,
  // Pins feeding the FIFO sync choice.
  input  wire logic         transmit_gate,
  input  wire logic         frame_sync_pin,
  input  wire logic         port_a_msb,
  input  wire logic         port_b_msb,
  // Sample datapath.
  input  wire logic         host_sample_enable,
  input  wire logic [7:0]   offset_a_low,
  input  wire logic [7:0]   offset_b_low,
  input  wire logic [15:0]  sample_a_in,
  input  wire logic [15:0]  sample_b_in,
  output logic [15:0]       sample_a_out,
  output logic [15:0]       sample_b_out,
  // Sync and load strobes.
  output logic              osc_accum_sync,
  output logic              osc_reg_load,
  output logic              correction_load,
  output logic              offset_load,
  output logic              fifo_sync,
  output logic [3:0]        fifo_out_position,
  output logic              channel_a_mark,
  // Power and pad controls.
  output logic              input_threshold_select,
  output logic              sleep_a,
  output logic              sleep_b,
  output logic              bias_filter_a_on,
  output logic              bias_filter_b_on,
  output logic [4:0]        full_scale_steps_a,
  output logic [4:0]        full_scale_steps_b
);

  logic [7:0]  offset_a_high;
  logic [7:0]  offset_b_high;
  logic [7:0]  host_sample_low;
  logic [7:0]  host_sample_high;
  logic [7:0]  datapath_trigger_select;
  logic [7:0]  fifo_trigger_select;
  logic [7:0]  fifo_start_position;
  logic [7:0]  power_and_pad_control;
  logic [7:0]  coarse_current_scale;
  logic [12:0] offset_a_active;
  logic [12:0] offset_b_active;
  logic [7:0]  next_rdata;
  logic [2:0]  fifo_sel;
  logic        fifo_rearm;
  logic        first_a_fire;
  logic        first_b_fire;
  logic        fifo_sync_evt;
  logic        offset_evt;
  logic        tx_gate_last;
  logic [15:0] host_word;
  logic [15:0] next_a;
  logic [15:0] next_b;

  function automatic logic pick_trigger(input logic [1:0] sel, input dsc_sync_in_t s);
    case (dsc_trig_t'(sel))
      DSC_TRIG_TX_GATE:    pick_trigger = s.tx_gate;
      DSC_TRIG_FRAME_SYNC: pick_trigger = s.frame_sync;
      DSC_TRIG_SERIAL:     pick_trigger = s.serial_trigger;
      default:             pick_trigger = 1'b0;
    endcase
  endfunction

  // Saturating add keeps a large offset from wrapping a full-scale sample to the other rail.
  function automatic logic [15:0] add_offset(input logic [15:0] s, input logic [12:0] o);
    logic [16:0] sum;
    sum = {s[15], s} + {{4{o[12]}}, o};
    if (sum[16] != sum[15]) begin
      add_offset = sum[16] ? 16'h8000 : 16'h7fff;
    end else begin
      add_offset = sum[15:0];
    end
  endfunction

  assign fifo_sel   = fifo_trigger_select[DSC_POS_FIFO_SEL +: 3];
  assign host_word  = {host_sample_high, host_sample_low}; // [R4]
  assign offset_evt = pick_trigger(datapath_trigger_select[DSC_POS_OFFSET_LOAD +: 2], sync_in); // [R9]
  // Only a write of a different code re-arms the one-shot sources.
  assign fifo_rearm = reg_req.write && (reg_req.addr == DSC_ADDR_FIFO_TRIG)
                      && (reg_req.wdata[DSC_POS_FIFO_SEL +: 3] != fifo_sel); // [R11]

  // Register writes. Spare locations hold nothing and always read zero.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      offset_a_high           <= DSC_RST_OFFSET_HIGH;
      offset_b_high           <= DSC_RST_OFFSET_HIGH;
      host_sample_low         <= DSC_RST_HOST_SAMPLE;
      host_sample_high        <= DSC_RST_HOST_SAMPLE;
      datapath_trigger_select <= DSC_RST_DATAPATH_TRIG;
      fifo_trigger_select     <= DSC_RST_FIFO_TRIG;
      fifo_start_position     <= DSC_RST_FIFO_START;
      power_and_pad_control   <= DSC_RST_POWER_PAD; // [R16]
      coarse_current_scale    <= DSC_RST_COARSE_SCALE; // [R18]
    end else if (reg_req.write) begin
      if (reg_req.addr == DSC_ADDR_OFFSET_A_HIGH) begin
        offset_a_high <= reg_req.wdata;
      end else if (reg_req.addr == DSC_ADDR_OFFSET_B_HIGH) begin
        offset_b_high <= reg_req.wdata;
      end else if (reg_req.addr == DSC_ADDR_HOST_SAMPLE_LOW) begin
        host_sample_low <= reg_req.wdata;
      end else if (reg_req.addr == DSC_ADDR_HOST_SAMPLE_HI) begin
        host_sample_high <= reg_req.wdata;
      end else if (reg_req.addr == DSC_ADDR_DATAPATH_TRIG) begin
        datapath_trigger_select <= reg_req.wdata;
      end else if (reg_req.addr == DSC_ADDR_FIFO_TRIG) begin
        fifo_trigger_select <= reg_req.wdata;
      end else if (reg_req.addr == DSC_ADDR_FIFO_START) begin
        fifo_start_position <= reg_req.wdata;
      end else if (reg_req.addr == DSC_ADDR_POWER_PAD) begin
        // Bits 1:0 are stored as written; software must leave them at one and zero. [R17]
        power_and_pad_control <= reg_req.wdata;
      end else if (reg_req.addr == DSC_ADDR_COARSE_SCALE) begin
        coarse_current_scale <= reg_req.wdata;
      end
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (reg_req.addr == DSC_ADDR_OFFSET_A_HIGH) begin
      next_rdata = offset_a_high;
    end else if (reg_req.addr == DSC_ADDR_OFFSET_B_HIGH) begin
      next_rdata = offset_b_high;
    end else if (reg_req.addr == DSC_ADDR_HOST_SAMPLE_LOW) begin
      next_rdata = host_sample_low;
    end else if (reg_req.addr == DSC_ADDR_HOST_SAMPLE_HI) begin
      next_rdata = host_sample_high;
    end else if (reg_req.addr == DSC_ADDR_DATAPATH_TRIG) begin
      next_rdata = datapath_trigger_select;
    end else if (reg_req.addr == DSC_ADDR_FIFO_TRIG) begin
      next_rdata = fifo_trigger_select;
    end else if (reg_req.addr == DSC_ADDR_FIFO_START) begin
      next_rdata = fifo_start_position;
    end else if (reg_req.addr == DSC_ADDR_POWER_PAD) begin
      next_rdata = power_and_pad_control;
    end else if (reg_req.addr == DSC_ADDR_COARSE_SCALE) begin
      next_rdata = coarse_current_scale;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.read;
      if (reg_req.read) begin
        reg_rdata <= next_rdata; // [R20]
      end
    end
  end

  // Offsets held in the active copy so a half-written pair never reaches the samples.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      offset_a_active <= 13'h0000;
      offset_b_active <= 13'h0000;
    end else if (offset_evt) begin
      offset_a_active <= {offset_a_high[4:0], offset_a_low}; // [R1] [R20]
      offset_b_active <= {offset_b_high[4:0], offset_b_low}; // [R2] [R20]
    end
  end

  assign next_a = host_sample_enable ? host_word : sample_a_in; // [R5]
  assign next_b = host_sample_enable ? host_word : sample_b_in; // [R5]

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sample_a_out <= 16'h0000;
      sample_b_out <= 16'h0000;
    end else begin
      sample_a_out <= add_offset(next_a, offset_a_active); // [R3]
      sample_b_out <= add_offset(next_b, offset_b_active); // [R3]
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      osc_accum_sync  <= 1'b0;
      osc_reg_load    <= 1'b0;
      correction_load <= 1'b0;
      offset_load     <= 1'b0;
    end else begin
      osc_accum_sync  <= pick_trigger(datapath_trigger_select[DSC_POS_OSC_ACCUM +: 2], sync_in); // [R6]
      osc_reg_load    <= pick_trigger(datapath_trigger_select[DSC_POS_OSC_LOAD +: 2], sync_in); // [R7]
      correction_load <= pick_trigger(datapath_trigger_select[DSC_POS_CORR_LOAD +: 2], sync_in); // [R8]
      offset_load     <= offset_evt; // [R9]
    end
  end

  dsc_msb_once u_first_a (
    .clock   (clock),
    .reset_n (reset_n),
    .rearm   (fifo_rearm),
    .msb     (port_a_msb),
    .fire    (first_a_fire)
  );

  dsc_msb_once u_first_b (
    .clock   (clock),
    .reset_n (reset_n),
    .rearm   (fifo_rearm),
    .msb     (port_b_msb),
    .fire    (first_b_fire)
  );

  always_comb begin
    case (fifo_sel)
      DSC_FIFO_TX_PIN:    fifo_sync_evt = transmit_gate; // [R10]
      DSC_FIFO_SYNC_PIN:  fifo_sync_evt = frame_sync_pin;
      DSC_FIFO_SERIAL:    fifo_sync_evt = sync_in.serial_trigger;
      DSC_FIFO_FIRST_A:   fifo_sync_evt = first_a_fire; // [R11]
      DSC_FIFO_FIRST_B:   fifo_sync_evt = first_b_fire; // [R11]
      DSC_FIFO_ALWAYS_ON: fifo_sync_evt = 1'b1;
      default:            fifo_sync_evt = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      fifo_sync         <= 1'b0;
      fifo_out_position <= 4'h0;
    end else begin
      fifo_sync <= fifo_sync_evt;
      if (fifo_sync_evt) begin
        fifo_out_position <= fifo_start_position[DSC_POS_FIFO_START +: 4]; // [R13]
      end else begin
        fifo_out_position <= fifo_out_position + 4'h1;
      end
    end
  end

  // The A mark uses the port opposite the data, so in the opposite-MSB mode port B marks A.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      tx_gate_last   <= 1'b0;
      channel_a_mark <= 1'b0;
    end else begin
      tx_gate_last <= transmit_gate;
      if (fifo_trigger_select[DSC_POS_AFLAG]) begin
        channel_a_mark <= port_b_msb; // [R12]
      end else begin
        channel_a_mark <= transmit_gate && !tx_gate_last; // [R12]
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      input_threshold_select <= 1'b0;
      sleep_a                <= 1'b0;
      sleep_b                <= 1'b0;
      bias_filter_a_on       <= 1'b0;
      bias_filter_b_on       <= 1'b0;
      full_scale_steps_a     <= 5'h10;
      full_scale_steps_b     <= 5'h10;
    end else begin
      input_threshold_select <= power_and_pad_control[DSC_POS_THRESHOLD]; // [R19]
      sleep_a                <= power_and_pad_control[DSC_POS_SLEEP_A]; // [R15]
      sleep_b                <= power_and_pad_control[DSC_POS_SLEEP_B]
                                || power_and_pad_control[DSC_POS_SLEEP_A]; // [R14] [R15]
      bias_filter_a_on       <= !power_and_pad_control[DSC_POS_BIAS_A]; // [R16]
      bias_filter_b_on       <= !power_and_pad_control[DSC_POS_BIAS_B]; // [R16]
      full_scale_steps_a     <= {1'b0, coarse_current_scale[DSC_POS_COARSE_A +: 4]} + 5'h01; // [R18]
      full_scale_steps_b     <= {1'b0, coarse_current_scale[DSC_POS_COARSE_B +: 4]} + 5'h01; // [R18]
    end
  end

  // Checks. Helper flag tracks a one-shot FIFO sync that has already fired.
  logic once_seen;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      once_seen <= 1'b0;
    end else if (fifo_rearm) begin
      once_seen <= 1'b0;
    end else if ((fifo_sel == DSC_FIFO_FIRST_A || fifo_sel == DSC_FIFO_FIRST_B) && fifo_sync_evt) begin
      once_seen <= 1'b1;
    end
  end

  sequence s_always_on;
    (fifo_sel == DSC_FIFO_ALWAYS_ON)[*2];
  endsequence

  sequence s_offset_quiet;
    !offset_evt ##1 !offset_evt;
  endsequence

  a_offset_a_load: assert property (@(posedge clock) disable iff (!reset_n) // [R1]
    offset_evt |=> offset_a_active == {$past(offset_a_high[4:0]), $past(offset_a_low)})
    else $error("offset A not loaded on its sync");

  a_offset_b_load: assert property (@(posedge clock) disable iff (!reset_n) // [R2]
    offset_evt |=> offset_b_active == {$past(offset_b_high[4:0]), $past(offset_b_low)})
    else $error("offset B not loaded on its sync");

  a_offset_hold: assert property (@(posedge clock) disable iff (!reset_n) // [R20]
    s_offset_quiet |=> $stable(offset_a_active) && $stable(offset_b_active))
    else $error("active offset changed without its sync");

  a_host_sample_route: assert property (@(posedge clock) disable iff (!reset_n) // [R5]
    (host_sample_enable && offset_a_active == 13'h0000 && offset_b_active == 13'h0000)
    |=> sample_a_out == $past(host_word) && sample_b_out == $past(host_word))
    else $error("host sample not on both channels");

  a_offset_never: assert property (@(posedge clock) disable iff (!reset_n) // [R9]
    datapath_trigger_select[1:0] == 2'h3 |=> !offset_load)
    else $error("offset load while selector says never");

  a_accum_frame: assert property (@(posedge clock) disable iff (!reset_n) // [R6]
    datapath_trigger_select[7:6] == 2'h1 |=> osc_accum_sync == $past(sync_in.frame_sync))
    else $error("accumulator sync does not follow frame sync");

  a_fifo_always_on: assert property (@(posedge clock) disable iff (!reset_n) // [R10]
    s_always_on |=> fifo_sync)
    else $error("constant-one FIFO sync missing");

  a_fifo_once: assert property (@(posedge clock) disable iff (!reset_n) // [R11]
    once_seen && !fifo_rearm && (fifo_sel == DSC_FIFO_FIRST_A || fifo_sel == DSC_FIFO_FIRST_B)
    |-> !fifo_sync_evt)
    else $error("first-transition sync fired twice");

  a_fifo_position: assert property (@(posedge clock) disable iff (!reset_n) // [R13]
    fifo_sync |-> fifo_out_position == $past(fifo_start_position[7:4]))
    else $error("FIFO position not loaded on sync");

  a_sleep_force: assert property (@(posedge clock) disable iff (!reset_n) // [R15]
    sleep_a |-> sleep_b)
    else $error("channel B awake while channel A sleeps");

  a_sleep_b_bit: assert property (@(posedge clock) disable iff (!reset_n) // [R14]
    power_and_pad_control[5] |=> sleep_b)
    else $error("channel B sleep bit ignored");

  a_bias_filter: assert property (@(posedge clock) disable iff (!reset_n) // [R16]
    ##1 bias_filter_a_on == !$past(power_and_pad_control[3]))
    else $error("bias filter A enable wrong");

  a_coarse_steps: assert property (@(posedge clock) disable iff (!reset_n) // [R18]
    ##1 full_scale_steps_a == {1'b0, $past(coarse_current_scale[7:4])} + 5'h01)
    else $error("coarse scale A wrong");

endmodule

// file: tb/tb_dsc_config_regs.sv
`timescale 1ns/1ps
module tb_dsc_config_regs
  import dsc_pkg::*;
;
  logic         clock;
  logic         reset_n;
  dsc_reg_req_t reg_req;
  logic [7:0]   reg_rdata;
  logic         reg_rvalid;
  dsc_sync_in_t sync_in;
  logic         transmit_gate;
  logic         frame_sync_pin;
  logic         port_a_msb;
  logic         port_b_msb;
  logic         host_sample_enable;
  logic [7:0]   offset_a_low;
  logic [7:0]   offset_b_low;
  logic [15:0]  sample_a_in;
  logic [15:0]  sample_b_in;
  logic [15:0]  sample_a_out;
  logic [15:0]  sample_b_out;
  logic [3:0]   strobes;
  logic         fifo_sync;
  logic [3:0]   fifo_out_position;
  logic         channel_a_mark;
  logic [4:0]   pwr;
  logic [4:0]   steps_a;
  logic [4:0]   steps_b;
  logic [7:0]   rd_data;
  int           fail_count;
  int           n_compared;
  int           cycles;

  dsc_config_regs dsc_config_regs_inst (
    .clock(clock), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .sync_in(sync_in), .transmit_gate(transmit_gate), .frame_sync_pin(frame_sync_pin),
    .port_a_msb(port_a_msb), .port_b_msb(port_b_msb), .host_sample_enable(host_sample_enable),
    .offset_a_low(offset_a_low), .offset_b_low(offset_b_low), .sample_a_in(sample_a_in),
    .sample_b_in(sample_b_in), .sample_a_out(sample_a_out), .sample_b_out(sample_b_out),
    .osc_accum_sync(strobes[3]), .osc_reg_load(strobes[2]), .correction_load(strobes[1]),
    .offset_load(strobes[0]), .fifo_sync(fifo_sync), .fifo_out_position(fifo_out_position),
    .channel_a_mark(channel_a_mark), .input_threshold_select(pwr[4]), .sleep_a(pwr[3]), .sleep_b(pwr[2]),
    .bias_filter_a_on(pwr[1]), .bias_filter_b_on(pwr[0]), .full_scale_steps_a(steps_a),
    .full_scale_steps_b(steps_b)
  );

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // A hang ends the run as a failure rather than stalling the simulator.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count = fail_count + 1;
      final_report();
    end
  end

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_compared = n_compared + 1;
    if (g !== e) begin
      fail_count = fail_count + 1;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock) reg_req <= dsc_reg_req_t'{1'b1, 1'b0, a, d};
    @(posedge clock) reg_req <= '0;
    repeat (2) @(posedge clock);
  endtask

  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clock) reg_req <= dsc_reg_req_t'{1'b0, 1'b1, a, 8'h00};
    @(posedge clock) reg_req <= '0;
    #1 chk("rvalid", 16'h0001, {15'h0000, reg_rvalid});
    d = reg_rdata;
  endtask

  task automatic test_reset_values();
    logic [7:0] rst[12];
    rst = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h15, 8'h15, 8'h80, 8'h00, 8'h0e, 8'hff, 8'h00, 8'h00};
    chk("pads", 16'h0000, {11'h000, pwr});
    chk("steps", {8'h10, 8'h10}, {3'h0, steps_a, 3'h0, steps_b});
    for (int i = 0; i < 12; i++) begin
      rd(5'h12 + 5'(i), rd_data);
      chk("reset value", {8'h00, rst[i]}, {8'h00, rd_data});
    end
    wr(DSC_ADDR_SPARE_A, 8'hff);
    rd(DSC_ADDR_SPARE_A, rd_data);
    chk("spare", 16'h0000, {8'h00, rd_data});
    wr(DSC_ADDR_OFFSET_B_HIGH, 8'h1f);
    rd(DSC_ADDR_OFFSET_B_HIGH, rd_data);
    chk("offset b high", 16'h001f, {8'h00, rd_data});
    $display("test reset_values done");
  endtask

  task automatic test_power();
    wr(DSC_ADDR_POWER_PAD, 8'h22);
    chk("pads", 16'h0007, {11'h000, pwr});
    wr(DSC_ADDR_POWER_PAD, 8'h9a);
    chk("pads", 16'h001d, {11'h000, pwr});
    wr(DSC_ADDR_COARSE_SCALE, 8'h0f);
    chk("steps", {8'h01, 8'h10}, {3'h0, steps_a, 3'h0, steps_b});
    $display("test power done");
  endtask

  task automatic test_offset_and_host();
    wr(DSC_ADDR_DATAPATH_TRIG, 8'h16);
    wr(DSC_ADDR_OFFSET_A_HIGH, 8'h00);
    repeat (3) @(posedge clock);
    chk("sample a", 16'h0100, sample_a_out);
    @(posedge clock) sync_in.serial_trigger <= 1'b1;
    @(posedge clock) sync_in.serial_trigger <= 1'b0;
    repeat (3) @(posedge clock);
    chk("sample a", 16'h0105, sample_a_out);
    chk("sample b", 16'h000f, sample_b_out);
    wr(DSC_ADDR_HOST_SAMPLE_LOW, 8'h34);
    wr(DSC_ADDR_HOST_SAMPLE_HI, 8'h12);
    @(posedge clock) host_sample_enable <= 1'b1;
    repeat (3) @(posedge clock);
    chk("host a", 16'h1239, sample_a_out);
    chk("host b", 16'h1233, sample_b_out);
    offset_a_low <= 8'h00;
    offset_b_low <= 8'h00;
    wr(DSC_ADDR_OFFSET_B_HIGH, 8'h00);
    @(posedge clock) sync_in.serial_trigger <= 1'b1;
    @(posedge clock) sync_in.serial_trigger <= 1'b0;
    repeat (3) @(posedge clock);
    chk("host plain a", 16'h1234, sample_a_out);
    chk("host plain b", 16'h1234, sample_b_out);
    $display("test offset_and_host done");
  endtask

  task automatic test_strobes();
    logic [7:0] sel[4];
    logic [3:0] exp[4];
    sel = '{8'h00, 8'h55, 8'haa, 8'hff};
    exp = '{4'hf, 4'hf, 4'hf, 4'h0};
    for (int i = 0; i < 4; i++) begin
      wr(DSC_ADDR_DATAPATH_TRIG, sel[i]);
      @(posedge clock) sync_in <= (i == 3) ? 3'h7 : 3'(3'h4 >> i);
      @(posedge clock) sync_in <= '0;
      #1 chk("strobes", {12'h000, exp[i]}, {12'h000, strobes});
      @(posedge clock);
      #1 chk("strobes idle", 16'h0000, {12'h000, strobes});
    end
    $display("test strobes done");
  endtask

  task automatic fifo_toggle(input bit use_b, input logic e);
    @(posedge clock) begin
      if (use_b) port_b_msb <= ~port_b_msb;
      else port_a_msb <= ~port_a_msb;
    end
    repeat (2) @(posedge clock);
    #1 chk("fifo sync", {15'h0000, e}, {15'h0000, fifo_sync});
    if (e) chk("position", 16'h0003, {12'h000, fifo_out_position});
    @(posedge clock);
    if (e) #1 chk("position next", 16'h0004, {12'h000, fifo_out_position});
  endtask

  task automatic test_fifo();
    wr(DSC_ADDR_FIFO_START, 8'h30);
    wr(DSC_ADDR_FIFO_TRIG, 8'h3c);
    chk("always one", 16'h0001, {15'h0000, fifo_sync});
    chk("position", 16'h0003, {12'h000, fifo_out_position});
    chk("mark", {15'h0000, port_b_msb}, {15'h0000, channel_a_mark});
    wr(DSC_ADDR_FIFO_TRIG, 8'h18);
    chk("always zero", 16'h0000, {15'h0000, fifo_sync});
    wr(DSC_ADDR_FIFO_TRIG, 8'h20);
    fifo_toggle(1'b0, 1'b1);
    fifo_toggle(1'b0, 1'b0);
    wr(DSC_ADDR_FIFO_TRIG, 8'h28);
    fifo_toggle(1'b1, 1'b1);
    $display("test fifo done");
  endtask

  task automatic test_gate();
    wr(DSC_ADDR_FIFO_TRIG, 8'h00);
    @(posedge clock) transmit_gate <= 1'b1;
    @(posedge clock);
    #1 chk("mark rise", 16'h0001, {15'h0000, channel_a_mark});
    chk("gate sync", 16'h0001, {15'h0000, fifo_sync});
    @(posedge clock) transmit_gate <= 1'b0;
    #1 chk("mark level", 16'h0000, {15'h0000, channel_a_mark});
    wr(DSC_ADDR_FIFO_TRIG, 8'h08);
    @(posedge clock) frame_sync_pin <= 1'b1;
    @(posedge clock) frame_sync_pin <= 1'b0;
    #1 chk("pin sync", 16'h0001, {15'h0000, fifo_sync});
    @(posedge clock);
    #1 chk("pin sync idle", 16'h0000, {15'h0000, fifo_sync});
    $display("test gate done");
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    fail_count = 0;
    n_compared = 0;
    cycles = 0;
    reset_n = 1'b0;
    reg_req = '0;
    sync_in = '0;
    transmit_gate = 1'b0;
    frame_sync_pin = 1'b0;
    port_a_msb = 1'b0;
    port_b_msb = 1'b1;
    host_sample_enable = 1'b0;
    offset_a_low = 8'h05;
    offset_b_low = 8'hff;
    sample_a_in = 16'h0100;
    sample_b_in = 16'h0010;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    test_reset_values();
    test_power();
    test_offset_and_host();
    test_strobes();
    test_fifo();
    test_gate();
    final_report();
  end
endmodule
